// [hw/tmr_core.sv]
// timer channel: events, staged divider, width mask, period and pulse
//
// The implementer's own choice: the address-and-strobe port.
module tmr_core
  import tmr_pkg::*;
#(
  parameter int CW = 16 // counter width
) (
  input wire logic core_clk, // 10 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] addr, // byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic cap_in, // external capture input
  output logic irq, // combined masked events
  output logic running // counter running
);
  import tmr_pkg::*;

  // ======================================================
  // registers
  logic [NUM_EV-1:0] ev_mask;
  logic [NUM_EV-1:0] ev_raw;
  logic [14:0] div_stg;
  logic [14:0] div_act;
  logic [3:0] wid_stg;
  logic [3:0] wid_act;
  logic [CW-1:0] prd_stg;
  logic [CW-1:0] prd_act;
  logic [CW-1:0] pul_stg;
  logic [CW-1:0] pul_act;
  logic [CW-1:0] count;
  logic [CW-1:0] cap_dn;
  logic wave_en;
  logic wrap_mode;
  logic capf_en;
  logic cap_q;
  logic [DIV_LIN_W-1:0] lin_cnt;
  logic [15:0] exp_cnt;
  logic [NUM_EV-1:0] ev_set;

  logic wr_ctl;
  logic do_start;
  logic do_stop;
  logic do_load;
  assign wr_ctl = wr && (addr == OFS_CTRL);
  assign do_start = wr_ctl && wdata[CTL_START];
  assign do_stop = wr_ctl && wdata[CTL_STOP] && !wdata[CTL_START];
  // start reloads the staged values as an update does
  assign do_load = wr_ctl && (wdata[CTL_UPDATE] || wdata[CTL_START]);

  // ======================================================
  // width mask as a value mask on the count
  logic [CW-1:0] wmask;
  always_comb begin
    wmask = '0;
    for (int i = 0; i < CW; i++) begin
      if (i <= int'(wid_act))
        wmask[i] = 1'b1;
    end
  end
  logic [CW-1:0] cnt_max;
  assign cnt_max = wmask;

  // ======================================================
  // staged registers and control bits
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_mask <= '0;
      div_stg <= '0;
      wid_stg <= WID_RESET;
      prd_stg <= '0;
      pul_stg <= '0;
      wave_en <= 1'b0;
      wrap_mode <= 1'b0;
      capf_en <= 1'b0;
    end else if (wr) begin
      if (addr == OFS_MASK)
        ev_mask <= wdata[NUM_EV-1:0];
      else if (addr == OFS_DIV)
        div_stg <= wdata[14:0];
      else if (addr == OFS_WID)
        wid_stg <= wdata[3:0];
      else if (addr == OFS_PRD)
        prd_stg <= wdata[CW-1:0];
      else if (addr == OFS_PUL)
        pul_stg <= wdata[CW-1:0];
      else if (addr == OFS_CTRL) begin
        wave_en <= wdata[CTL_WAVE];
        wrap_mode <= wdata[CTL_WRAP];
        capf_en <= wdata[CTL_CAPF];
      end
    end
  end

  // ======================================================
  // active copies
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_act <= '0;
      wid_act <= WID_RESET;
      prd_act <= '0;
      pul_act <= '0;
    end else if (do_load) begin
      div_act <= div_stg;
      wid_act <= wid_stg;
      prd_act <= prd_stg;
      pul_act <= pul_stg;
    end
  end

  // ======================================================
  // prescaler: linear stage then power-of-two stage
  logic lin_tick;
  logic tick;
  logic [15:0] exp_lim;
  // >= so a smaller divider loaded mid-run cannot strand the stage counters
  assign lin_tick = running && (lin_cnt >= div_act[DIV_LIN_LSB +: DIV_LIN_W]);
  assign exp_lim = 16'((32'd1 << div_act[DIV_EXP_LSB +: DIV_EXP_W]) - 32'd1);
  assign tick = lin_tick && (exp_cnt >= exp_lim);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lin_cnt <= '0;
      exp_cnt <= '0;
    end else if (!running || do_start) begin
      lin_cnt <= '0;
      exp_cnt <= '0;
    end else if (lin_tick) begin
      lin_cnt <= '0;
      exp_cnt <= tick ? 16'h0000 : exp_cnt + 16'h0001;
    end else begin
      lin_cnt <= lin_cnt + DIV_LIN_W'(1);
    end
  end

  // ======================================================
  // counter
  logic at_prd;
  logic at_max;
  assign at_prd = (count == (prd_act & wmask));
  assign at_max = (count == cnt_max);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 1'b0;
    end else if (do_start) begin
      running <= 1'b1;
    end else if (do_stop) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= CNT_RESET;
    end else if (do_start) begin
      count <= CNT_RESET;
    end else if (tick) begin
      if (wrap_mode ? at_max : at_prd)
        count <= CNT_RESET;
      else
        count <= (count + CW'(1)) & wmask;
    end
  end

  // ======================================================
  // capture on falling edge; input is synchronous
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_q <= 1'b0;
      cap_dn <= '0;
    end else begin
      cap_q <= cap_in;
      if (capf_en && cap_q && !cap_in)
        cap_dn <= count;
    end
  end

  // ======================================================
  // event sources
  always_comb begin
    ev_set = '0;
    // run begin
    // enable written beside start counts, it is stored in that same write
    ev_set[EV_RUN_BEGIN] = do_start && wdata[CTL_WAVE];
    ev_set[EV_RUN_HALT] = do_stop && running && wave_en;
    ev_set[EV_PRD_BEGIN] = running && tick && (count == CNT_RESET);
    ev_set[EV_PRD_FINISH] = running && tick && at_prd;
    ev_set[EV_PULSE] = running && tick && (count == (pul_act & wmask));
    ev_set[EV_WRAP] = running && tick && wrap_mode && at_max;
    ev_set[EV_CAPTURE] = capf_en && cap_q && !cap_in;
  end

  // sticky flags; a set in the clearing cycle wins
  logic [NUM_EV-1:0] ev_clr;
  assign ev_clr = (wr && addr == OFS_CLR) ? wdata[NUM_EV-1:0] : '0;

  generate
    for (genvar g = 0; g < NUM_EV; g++) begin : g_flag
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
          ev_raw[g] <= 1'b0;
        else if (ev_set[g])
          ev_raw[g] <= 1'b1;
        else if (ev_clr[g])
          ev_raw[g] <= 1'b0;
      end
    end
  endgenerate

  // ======================================================
  // interrupt output from next-state flags keeps it registered
  logic [NUM_EV-1:0] next_raw;
  assign next_raw = ev_set | (ev_raw & ~ev_clr);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(next_raw & (wr && addr == OFS_MASK ? wdata[NUM_EV-1:0] : ev_mask));
  end

  // ======================================================
  // read port; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= '0;
      if (addr == OFS_MASK)
        rdata[NUM_EV-1:0] <= ev_mask;
      else if (addr == OFS_RAW)
        rdata[NUM_EV-1:0] <= ev_raw;
      else if (addr == OFS_MSK_ST)
        rdata[NUM_EV-1:0] <= ev_raw & ev_mask;
      else if (addr == OFS_DIV)
        rdata[14:0] <= div_stg;
      else if (addr == OFS_WID)
        rdata[3:0] <= wid_stg;
      else if (addr == OFS_PRD)
        rdata[CW-1:0] <= prd_stg;
      else if (addr == OFS_PUL)
        rdata[CW-1:0] <= pul_stg;
      else if (addr == OFS_DIV_ACT)
        rdata[14:0] <= div_act;
      else if (addr == OFS_WID_ACT)
        rdata[3:0] <= wid_act;
      else if (addr == OFS_PRD_ACT)
        rdata[CW-1:0] <= prd_act;
      else if (addr == OFS_PUL_ACT)
        rdata[CW-1:0] <= pul_act;
      else if (addr == OFS_CAP_DN)
        rdata[CW-1:0] <= cap_dn;
      else if (addr == OFS_COUNT)
        rdata[CW-1:0] <= count;
      else if (addr == OFS_CTRL)
        rdata[5:0] <= {capf_en, wrap_mode, wave_en, 2'b00, running};
    end
  end

  // ======================================================
  // checks
  sequence s_load;
    do_load;
  endsequence

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(ev_raw[EV_WRAP]) |-> $past(ev_clr[EV_WRAP])) else $error("flag fell without clear");
  a_load_group: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_load |=> (prd_act == $past(prd_stg)) && (wid_act == $past(wid_stg))) else $error("load not together");
  a_div_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    !do_load |=> $stable(div_act)) else $error("divider moved without command");
  a_clear_one: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ev_clr[EV_CAPTURE] && !ev_set[EV_CAPTURE]) |=> !ev_raw[EV_CAPTURE]) else $error("clear failed");
  a_start_ev: assert property (@(posedge core_clk) disable iff (!arst_n)
    (do_start && wdata[CTL_WAVE]) |=> ev_raw[EV_RUN_BEGIN]) else $error("run begin not raised");
  a_masked_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd && addr == OFS_MSK_ST) |=> rdata == {25'h0, $past(ev_raw & ev_mask)}) else $error("masked read wrong");
  a_irq_or: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 irq == |(ev_raw & ev_mask)) else $error("irq mismatch");
  a_cap_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (capf_en && cap_q && !cap_in) |=> cap_dn == $past(count)) else $error("capture missed");

  // ======================================================
  // event, hold and view checks
  sequence s_clear_wr;
    wr && (addr == OFS_CLR);
  endsequence

  sequence s_halt_req;
    do_stop && running && wave_en;
  endsequence

  sequence s_wrap_hit;
    running && tick && wrap_mode && at_max;
  endsequence

  a_mask_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr && addr == OFS_MASK) |=> ev_mask == $past(wdata[NUM_EV-1:0])) else $error("mask write lost");
  a_halt_ev: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_halt_req |=> ev_raw[EV_RUN_HALT]) else $error("run halt not raised");
  a_prd_begin: assert property (@(posedge core_clk) disable iff (!arst_n)
    (running && tick && count == CNT_RESET) |=> ev_raw[EV_PRD_BEGIN]) else $error("period begin missed");
  a_prd_finish: assert property (@(posedge core_clk) disable iff (!arst_n)
    (running && tick && at_prd) |=> ev_raw[EV_PRD_FINISH]) else $error("period finish missed");
  a_pulse_ev: assert property (@(posedge core_clk) disable iff (!arst_n)
    (running && tick && count == (pul_act & wmask)) |=> ev_raw[EV_PULSE]) else $error("pulse match missed");
  a_wrap_ev: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_wrap_hit |=> ev_raw[EV_WRAP] && (count == CNT_RESET)) else $error("wrap not flagged");
  a_capture_ev: assert property (@(posedge core_clk) disable iff (!arst_n)
    (capf_en && cap_q && !cap_in) |=> ev_raw[EV_CAPTURE]) else $error("capture flag missed");
  a_raw_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd && addr == OFS_RAW) |=> rdata == {25'h0, $past(ev_raw)}) else $error("raw read wrong");
  a_flags_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(wr && addr == OFS_CLR) |=> (ev_raw & $past(ev_raw)) == $past(ev_raw)) else $error("flag dropped");
  a_clear_all: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_clear_wr |=> (ev_raw & $past(ev_clr & ~ev_set)) == '0) else $error("clear left a flag set");
  a_stage_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    !do_load |=> $stable(prd_act) && $stable(pul_act) && $stable(wid_act)) else $error("active copy moved");
  a_div_view: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd && addr == OFS_DIV_ACT) |=> rdata == {17'h0, $past(div_act)}) else $error("divider view wrong");
  a_wid_view: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd && addr == OFS_WID_ACT) |=> rdata == {28'h0, $past(wid_act)}) else $error("width view wrong");
  a_upper_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rd && (addr == OFS_PRD || addr == OFS_PUL)) |=> rdata[31:16] == 16'h0000) else $error("upper half set");
  a_tick_full: assert property (@(posedge core_clk) disable iff (!arst_n)
    (running && div_act == 15'h0000) |-> tick) else $error("undivided tick missing");
endmodule

// [inc/tmr_pkg.sv]
// timer channel register map, field layout and reset values
package tmr_pkg;
  // ======================================================
  // register offsets
  localparam logic [7:0] OFS_MASK = 8'h1C;
  localparam logic [7:0] OFS_RAW = 8'h20;
  localparam logic [7:0] OFS_MSK_ST = 8'h24;
  localparam logic [7:0] OFS_CLR = 8'h28;
  localparam logic [7:0] OFS_DIV = 8'h2C;
  localparam logic [7:0] OFS_WID = 8'h30;
  localparam logic [7:0] OFS_PRD = 8'h34;
  localparam logic [7:0] OFS_PUL = 8'h38;
  localparam logic [7:0] OFS_DIV_ACT = 8'h3C;
  localparam logic [7:0] OFS_WID_ACT = 8'h40;
  localparam logic [7:0] OFS_PRD_ACT = 8'h44;
  localparam logic [7:0] OFS_PUL_ACT = 8'h48;
  localparam logic [7:0] OFS_CAP_DN = 8'h50;
  localparam logic [7:0] OFS_COUNT = 8'h54;
  localparam logic [7:0] OFS_CTRL = 8'h60;
  // ======================================================
  // event bit positions
  localparam int EV_RUN_BEGIN = 0;
  localparam int EV_RUN_HALT = 1;
  localparam int EV_PRD_BEGIN = 2;
  localparam int EV_PRD_FINISH = 3;
  localparam int EV_PULSE = 4;
  localparam int EV_WRAP = 5;
  localparam int EV_CAPTURE = 6;
  localparam int NUM_EV = 7;
  // ======================================================
  // divider fields
  localparam int DIV_EXP_LSB = 0;
  localparam int DIV_EXP_W = 4;
  localparam int DIV_LIN_LSB = 4;
  localparam int DIV_LIN_W = 11;
  // ======================================================
  // control register bits (own register)
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_UPDATE = 2;
  localparam int CTL_WAVE = 3;
  localparam int CTL_WRAP = 4;
  localparam int CTL_CAPF = 5;
  // ======================================================
  // reset values
  localparam logic [3:0] WID_RESET = 4'hF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

// [test/tb_timer_irq_divider_period_regs.sv]
// self-checking bench for the timer channel event, divider and period registers
module tb_timer_irq_divider_period_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic core_clk, arst_n, wr, rd, cap_in, irq, running;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, rv2, d, w, p, u, pd, pw, pp, pu;
  logic [15:0] seed;
  logic [7:0] ofs [13];
  logic [31:0] rst_val [13];
  int n_fail, check_count;

  tmr_core #(.CW(16)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cap_in(cap_in), .irq(irq), .running(running));

  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] f_masked(input logic [31:0] m, input logic [31:0] r);
    return m & r & 32'h0000_007F;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(name, exp, v);
  endtask
  // bounded poll: a flag that never rises ends the run
  task automatic wait_flag(input int b);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      rd_reg(OFS_RAW, v);
      if (v[b] === 1'b1) begin
        return;
      end
    end
    n_fail++;
    $display("[ERR] raw flag %0d expected 1 seen 0", b);
    wrap_up();
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    arst_n = 1'b0; wr = 1'b0; rd = 1'b0; cap_in = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    n_fail = 0; check_count = 0; seed = 16'd53652;
    ofs = '{OFS_MASK, OFS_RAW, OFS_MSK_ST, OFS_DIV, OFS_WID, OFS_PRD, OFS_PUL, OFS_DIV_ACT, OFS_WID_ACT,
      OFS_PRD_ACT, OFS_PUL_ACT, OFS_CAP_DN, OFS_COUNT};
    rst_val = '{0, 0, 0, 0, 32'h0000_000F, 0, 0, 0, 32'h0000_000F, 0, 0, 0, 0};
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    // ==========================================
    // reset values and unmapped read
    foreach (ofs[i]) chk_rd("reset value", ofs[i], rst_val[i]);
    chk_rd("unmapped", 8'h04, 32'h0000_0000);
    // ==========================================
    // staged values stay hidden until update, then move together
    pd = 0; pw = 32'h0000_000F; pp = 0; pu = 0;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed); d = {seed, seed}; seed = lfsr(seed); w = {seed, seed};
      seed = lfsr(seed); p = {~seed, seed}; seed = lfsr(seed); u = {seed, ~seed};
      if (k == 0) w = 32'h0000_0007;
      if (k == 1) w = 32'h0000_0009;
      wr_reg(OFS_DIV, d); wr_reg(OFS_WID, w); wr_reg(OFS_PRD, p); wr_reg(OFS_PUL, u);
      chk_rd("div staged", OFS_DIV, d & 32'h0000_7FFF);
      chk_rd("wid staged", OFS_WID, w & 32'h0000_000F);
      chk_rd("prd staged", OFS_PRD, p & 32'h0000_FFFF);
      chk_rd("pul staged", OFS_PUL, u & 32'h0000_FFFF);
      chk_rd("div active", OFS_DIV_ACT, pd);
      chk_rd("wid active", OFS_WID_ACT, pw);
      chk_rd("prd active", OFS_PRD_ACT, pp);
      chk_rd("pul active", OFS_PUL_ACT, pu);
      wr_reg(OFS_CTRL, 32'h0000_0004);
      pd = d & 32'h0000_7FFF; pw = w & 32'h0000_000F; pp = p & 32'h0000_FFFF; pu = u & 32'h0000_FFFF;
      chk_rd("div updated", OFS_DIV_ACT, pd);
      chk_rd("wid updated", OFS_WID_ACT, pw);
      chk_rd("prd updated", OFS_PRD_ACT, pp);
      chk_rd("pul updated", OFS_PUL_ACT, pu);
    end
    wr_reg(OFS_DIV_ACT, 32'hFFFF_FFFF); wr_reg(OFS_WID_ACT, 32'hFFFF_FFFF);
    chk_rd("div active ro", OFS_DIV_ACT, pd);
    chk_rd("wid active ro", OFS_WID_ACT, pw);
    // ==========================================
    // divider rate: linear 1, exponent 1 gives one tick per four clocks
    wr_reg(OFS_DIV, 32'h0000_0011); wr_reg(OFS_WID, 32'h0000_000F); wr_reg(OFS_PRD, 32'h0000_FFFF);
    wr_reg(OFS_CTRL, 32'h0000_0001);
    #1;
    chk("running", 1'b1, running);
    rd_reg(OFS_COUNT, rv);
    repeat (38) @(posedge core_clk);
    rd_reg(OFS_COUNT, rv2);
    chk("tick count", 32'd10, rv2 - rv);
    // ==========================================
    // wave run: start, period begin/finish, pulse, stop
    wr_reg(OFS_CTRL, 32'h0000_0002); wr_reg(OFS_CLR, 32'h0000_007F);
    chk_rd("raw cleared", OFS_RAW, 32'h0000_0000);
    wr_reg(OFS_DIV, 32'h0000_0000); wr_reg(OFS_PRD, 32'h0000_0010); wr_reg(OFS_PUL, 32'h0000_0008);
    wr_reg(OFS_CTRL, 32'h0000_0009);
    repeat (50) @(posedge core_clk);
    chk_rd("raw after run", OFS_RAW, 32'h0000_001D);
    wr_reg(OFS_CTRL, 32'h0000_000A);
    #1;
    chk("stopped", 1'b0, running);
    wr_reg(OFS_RAW, 32'h0000_0000); wr_reg(OFS_MSK_ST, 32'h0000_0000);
    chk_rd("raw after stop", OFS_RAW, 32'h0000_001F);
    chk("irq masked off", 1'b0, irq);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wr_reg(OFS_MASK, {seed, seed});
      chk_rd("mask", OFS_MASK, {seed, seed} & 32'h0000_007F);
      chk_rd("masked", OFS_MSK_ST, f_masked({seed, seed}, 32'h0000_001F));
      chk_rd("raw unmasked", OFS_RAW, 32'h0000_001F);
      chk("irq", |f_masked({seed, seed}, 32'h0000_001F), irq);
    end
    wr_reg(OFS_MASK, 32'h0000_007F);
    wr_reg(OFS_CLR, 32'h0000_0015);
    chk_rd("partial clear", OFS_RAW, 32'h0000_000A);
    chk("irq still", 1'b1, irq);
    wr_reg(OFS_CLR, 32'h0000_000A);
    chk_rd("full clear", OFS_MSK_ST, 32'h0000_0000);
    chk("irq low", 1'b0, irq);
    // ==========================================
    // wrap mode with an eight-bit counter
    wr_reg(OFS_WID, 32'h0000_0007); wr_reg(OFS_PRD, 32'h0000_0005);
    wr_reg(OFS_CTRL, 32'h0000_0011);
    wait_flag(EV_WRAP);
    for (int k = 0; k < 6; k++) begin
      rd_reg(OFS_COUNT, rv);
      chk("count width", 32'h0000_0000, rv & 32'hFFFF_FF00);
    end
    // ==========================================
    // falling-edge capture
    wr_reg(OFS_CTRL, 32'h0000_0002); wr_reg(OFS_CLR, 32'h0000_007F);
    wr_reg(OFS_PRD, 32'h0000_00FF);
    wr_reg(OFS_CTRL, 32'h0000_0021);
    cap_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_reg(OFS_RAW, rv);
    chk("no capture on rise", 32'h0000_0000, rv & 32'h0000_0040);
    cap_in <= 1'b0;
    wait_flag(EV_CAPTURE);
    rd_reg(OFS_CAP_DN, rv);
    chk("capture upper", 32'h0000_0000, rv & 32'hFFFF_FF00);
    chk("capture nonzero", 1'b1, rv != 32'h0000_0000);
    wrap_up();
  end
endmodule
